//--- sync_pwm_phase_timer.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "sync_pwm_phase_timer_consts.svh"
module sync_pwm_phase_timer
    import sync_pwm_phase_timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  pin_a_in,
    output logic [2:0]       pin_a_out,
    output logic [2:0]       pin_a_oe,
    input  wire logic [2:0]  pin_b_in,
    output logic [2:0]       pin_b_out,
    output logic [2:0]       pin_b_oe,
    input  wire logic        quad_input_a,
    input  wire logic        quad_input_b,
    output logic [8:0]       request,
    output logic [3:0]       top_request,
    output logic             any_request
);

////////////////////////////////////////////////////////////////////////////////

    function automatic logic [11:0] ch_addr(input int ch, input logic [11:0] o);
        ch_addr = 12'(`CH_BASE + ch * `CH_STRIDE) + o;
    endfunction

    // Channels whose priority bit is set go first; ties keep channel order.
    function automatic logic [3:0] top_pick(input logic [8:0] req,
                                            input logic [2:0] raise);
        logic [3:0] pick;
        pick = 4'hf;
        for (int pass = 1; pass >= 0; pass--) begin
            for (int c = 0; c < 3; c++) begin
                for (int k = 0; k < 3; k++) begin
                    if (raise[c] == pass[0] && req[c*3+k] && pick == 4'hf) begin
                        pick = 4'(c * 3 + k);
                    end
                end
            end
        end
        top_pick = pick;
    endfunction

////////////////////////////////////////////////////////////////////////////////

    logic        wr_en;
    logic        rd_en;
    logic [2:0]  run_reg;
    logic [2:0]  run_q_reg;
    logic [8:0]  mode_reg;
    logic [5:0]  level_reg;
    logic [2:0]  prio_reg;
    logic [8:0]  flags_reg;
    logic [8:0]  seen_reg;
    logic [8:0]  enable_reg;
    logic [2:0]  presc_reg;
    logic        qa_q_reg;
    logic        qb_q_reg;
    logic [8:0]  flag_set;
    logic [2:0]  sync_clr;
    logic [2:0]  clr_v;
    logic [2:0]  tick_v;
    logic [2:0]  ma_v;
    logic [2:0]  mb_v;
    logic [2:0]  capa_v;
    logic        q_up;
    logic        q_dn;
    logic [2:0]  cnt_hit;
    logic [1:0]  wr_ch;
    logic        cnt_wr;
    count_t      load_val;
    count_t      cnt_view [3];
    count_t      gra_view [3];
    count_t      grb_view [3];
    logic [5:0]  ctl_view [3];
    logic [31:0] rd_data;
    logic        addr_ok;
    logic [2:0]  sync_sel;
    logic [2:0]  pwm_sel;

    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign pready   = psel & penable;
    assign sync_sel = mode_reg[`MODE_SYNC_LSB +: 3];
    assign pwm_sel  = mode_reg[`MODE_PWM_LSB +: 3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg    <= 3'h0;
            mode_reg   <= 9'h000;
            level_reg  <= 6'h00;
            prio_reg   <= 3'h0;
            enable_reg <= 9'h000;
        end else if (wr_en) begin
            if (paddr == `RUN_OFS) run_reg <= pwdata[2:0];
            if (paddr == `MODE_OFS) mode_reg <= pwdata[8:0];
            if (paddr == `LEVEL_OFS) level_reg <= pwdata[5:0];
            if (paddr == `PRIO_OFS) prio_reg <= pwdata[2:0];
            if (paddr == `ENABLE_OFS) enable_reg <= pwdata[8:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q_reg <= 3'h0;
            presc_reg <= 3'h0;
            qa_q_reg  <= 1'b0;
            qb_q_reg  <= 1'b0;
        end else begin
            run_q_reg <= run_reg;
            presc_reg <= presc_reg + 3'h1;
            qa_q_reg  <= quad_input_a;
            qb_q_reg  <= quad_input_b;
        end
    end

    // Edges are seen once per clock, so the source must respect the minimum
    // phase gap and pulse width or steps are lost.  see R12
    always_comb begin
        q_up = (quad_input_b & ~qb_q_reg & ~quad_input_a)    // see R10
             | (quad_input_a & ~qa_q_reg &  quad_input_b)    // see R11
             | (~quad_input_b & qb_q_reg &  quad_input_a)
             | (~quad_input_a & qa_q_reg & ~quad_input_b);
        q_dn = (quad_input_b & ~qb_q_reg &  quad_input_a)
             | (quad_input_a & ~qa_q_reg & ~quad_input_b)
             | (~quad_input_b & qb_q_reg & ~quad_input_a)
             | (~quad_input_a & qa_q_reg &  quad_input_b);
    end

    // A count write to a synced channel fans out to every synced counter with the merged word.
    always_comb begin
        wr_ch    = 2'd0;
        cnt_wr   = 1'b0;
        load_val = cnt_view[0];
        for (int c = 0; c < 3; c++) begin
            if (wr_en && paddr == ch_addr(c, `CNT_OFS)) begin
                wr_ch    = 2'(c);
                cnt_wr   = 1'b1;
                load_val = cnt_view[c];
            end
        end
        if (pstrb[0]) load_val[7:0] = pwdata[7:0];     // see R24
        if (pstrb[1]) load_val[15:8] = pwdata[15:8];
    end

////////////////////////////////////////////////////////////////////////////////

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : ch   // see R26
            logic [5:0] ctl_reg;
            count_t     cnt_reg;
            count_t     gra_reg;
            count_t     grb_reg;
            logic       out_a_reg;
            logic       out_b_reg;
            logic       pa_q_reg;
            logic       pb_q_reg;
            logic       phase;
            logic       pwm;
            logic       up;
            logic       tick;
            logic       cap_a;
            logic       cap_b;
            logic       eq_a;
            logic       eq_b;
            logic       m_a;
            logic       m_b;
            logic       clr_own;
            logic       clr;
            logic       load;
            logic       wrap;
            logic [1:0] psc;
            clr_sel_e   csel;

            assign phase = (i == 2) && mode_reg[`MODE_PHASE_BIT];  // see R7
            assign pwm   = pwm_sel[i];
            assign psc   = ctl_reg[`CTL_PSC_LSB +: 2];
            assign csel  = clr_sel_e'(ctl_reg[`CTL_CLR_LSB +: 2]);
            assign up    = phase ? q_up : 1'b1;
            // Phase mode overrides the clock source, not the run bit.
            assign tick  = run_reg[i] & (phase ? (q_up | q_dn)   // see R8
                         : (psc == 2'd0) | (presc_reg[1:0] == 2'd3 && psc == 2'd3)
                         | (presc_reg[0] && psc == 2'd1)
                         | (presc_reg[1:0] == 2'd1 && psc == 2'd2));
            // Capture is blocked in PWM; a set capture bit still blocks compare.  see R22
            assign cap_a = ctl_reg[`CTL_CAPA_BIT] & ~pwm & pin_a_in[i] & ~pa_q_reg;
            assign cap_b = ctl_reg[`CTL_CAPB_BIT] & ~pwm & pin_b_in[i] & ~pb_q_reg;
            // Match fires as the counter leaves the value.  see R15
            assign eq_a  = tick & (cnt_reg == gra_reg) & ~ctl_reg[`CTL_CAPA_BIT];
            assign eq_b  = tick & (cnt_reg == grb_reg) & ~ctl_reg[`CTL_CAPB_BIT];
            assign m_a   = eq_a & ~(pwm & eq_b);     // see R23
            assign m_b   = eq_b & ~(pwm & eq_a);     // see R4
            assign clr_own = (csel == CLR_A & (m_a | cap_a))   // see R25
                           | (csel == CLR_B & (m_b | cap_b));  // see R5
            assign sync_clr[i] = clr_own & sync_sel[i];
            assign clr = clr_own | (csel == CLR_SYNC & sync_sel[i]   // see R2
                       & |(sync_clr & ~(3'b001 << i)));
            assign load = cnt_wr & (wr_ch == 2'(i)    // see R1
                        | (sync_sel[i] & sync_sel[wr_ch]));
            assign wrap = tick & ~clr & (up ? cnt_reg == `CNT_MAX
                                            : cnt_reg == `CNT_RESET); // see R17

            assign flag_set[i*3]   = m_a | cap_a;  // see R16
            assign flag_set[i*3+1] = m_b | cap_b;
            assign flag_set[i*3+2] = wrap;
            assign clr_v[i]  = clr;
            assign tick_v[i] = tick;
            assign ma_v[i]   = m_a;
            assign mb_v[i]   = m_b;
            assign capa_v[i] = cap_a;
            assign cnt_view[i] = cnt_reg;
            assign gra_view[i] = gra_reg;
            assign grb_view[i] = grb_reg;
            assign ctl_view[i] = ctl_reg;
            assign pin_a_out[i] = out_a_reg;
            assign pin_b_out[i] = out_b_reg;
            assign pin_a_oe[i]  = pwm | ~ctl_reg[`CTL_CAPA_BIT];  // see R6
            assign pin_b_oe[i]  = ~pwm & ~ctl_reg[`CTL_CAPB_BIT];

            // Clear beats a write, and a write beats a count step.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= `CNT_RESET;
                end else if (clr) begin
                    cnt_reg <= `CNT_RESET;
                end else if (load) begin
                    cnt_reg <= load_val;
                end else if (tick) begin
                    cnt_reg <= up ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
                end
            end

            // Capture wins over a register write in the same cycle.  see R9
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctl_reg <= 6'h00;
                    gra_reg <= `GR_RESET;
                    grb_reg <= `GR_RESET;
                end else begin
                    if (wr_en && paddr == ch_addr(i, `CTL_OFS)) ctl_reg <= pwdata[5:0];
                    if (cap_a) gra_reg <= cnt_reg;
                    else if (wr_en && paddr == ch_addr(i, `GRA_OFS))
                        gra_reg <= pwdata[15:0];
                    if (cap_b) grb_reg <= cnt_reg;
                    else if (wr_en && paddr == ch_addr(i, `GRB_OFS))
                        grb_reg <= pwdata[15:0];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_a_reg <= 1'b0;
                    out_b_reg <= 1'b0;
                    pa_q_reg  <= 1'b0;
                    pb_q_reg  <= 1'b0;
                end else begin
                    pa_q_reg <= pin_a_in[i];
                    pb_q_reg <= pin_b_in[i];
                    if (run_reg[i] & ~run_q_reg[i]) begin
                        out_a_reg <= level_reg[i*2];     // see R13
                        out_b_reg <= level_reg[i*2+1];
                    end else if (pwm) begin
                        if (m_a) out_a_reg <= 1'b1;      // see R3
                        else if (m_b) out_a_reg <= 1'b0;
                    end else begin
                        if (m_a) out_a_reg <= ~out_a_reg;
                        if (m_b) out_b_reg <= ~out_b_reg;
                    end
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////

    // A hardware set in the same cycle as a clear keeps the flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= 9'h000;
            seen_reg  <= 9'h000;
        end else begin
            if (rd_en && paddr == `STATUS_OFS) begin
                // Arm only what software saw as 1 in the setup cycle.
                seen_reg <= seen_reg | prdata[8:0];
            end else if (wr_en && paddr == `STATUS_OFS) begin
                seen_reg <= seen_reg & pwdata[8:0];
            end
            if (wr_en && paddr == `STATUS_OFS) begin
                flags_reg <= flag_set                     // see R18
                           | (flags_reg & ~(seen_reg & ~pwdata[8:0]));
            end else begin
                flags_reg <= flags_reg | flag_set;
            end
        end
    end

    assign request     = flags_reg & enable_reg;          // see R21
    assign top_request = top_pick(request, prio_reg);     // see R20
    assign any_request = |request;                        // see R19

    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            `RUN_OFS:    rd_data[2:0] = run_reg;
            `MODE_OFS:   rd_data[8:0] = mode_reg;
            `LEVEL_OFS:  rd_data[5:0] = level_reg;
            `PRIO_OFS:   rd_data[2:0] = prio_reg;
            `STATUS_OFS: rd_data[8:0] = flags_reg;
            `ENABLE_OFS: rd_data[8:0] = enable_reg;
            default: begin
                addr_ok = 1'b0;
                for (int c = 0; c < 3; c++) begin
                    if (paddr == ch_addr(c, `CTL_OFS)) begin
                        rd_data[5:0] = ctl_view[c];
                        addr_ok = 1'b1;
                    end
                    if (paddr == ch_addr(c, `CNT_OFS)) begin
                        rd_data[15:0] = cnt_view[c];
                        addr_ok = 1'b1;
                    end
                    if (paddr == ch_addr(c, `GRA_OFS)) begin
                        rd_data[15:0] = gra_view[c];
                        addr_ok = 1'b1;
                    end
                    if (paddr == ch_addr(c, `GRB_OFS)) begin
                        rd_data[15:0] = grb_view[c];
                        addr_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            prdata <= rd_data;
        end
    end

    assign pslverr = psel & penable & ~addr_ok;

////////////////////////////////////////////////////////////////////////////////

    sync_preset_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
        cnt_wr && wr_ch == 2'd0 && sync_sel[1:0] == 2'b11 && clr_v[1:0] == 2'b00
        |=> cnt_view[0] == cnt_view[1]) else $error("synced preset differs");
    sync_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
        sync_clr[0] && sync_sel[1] && ctl_view[1][1:0] == 2'b11
        |-> clr_v[1]) else $error("synced clear missed");
    pwm_high_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
        pwm_sel[0] && ma_v[0] && !(run_reg[0] && !run_q_reg[0])
        |=> pin_a_out[0]) else $error("pwm did not rise");
    pwm_equal_a: assert property (@(posedge pclk) disable iff (!presetn) // see R23
        pwm_sel[0] && gra_view[0] == grb_view[0] && ctl_view[0][3:2] == 2'b00
        |-> !ma_v[0] && !mb_v[0]) else $error("equal match not suppressed");
    pwm_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        pwm_sel[0] |-> pin_a_oe[0]) else $error("pwm pin not driven");
    quad_up_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        mode_reg[`MODE_PHASE_BIT] && run_reg[2] && q_up && !clr_v[2] && !cnt_wr
        |=> cnt_view[2] == $past(cnt_view[2]) + 16'h0001)
        else $error("quad up step lost");
    capture_a: assert property (@(posedge pclk) disable iff (!presetn) // see R16
        capa_v[1] |=> gra_view[1] == $past(cnt_view[1]) && flags_reg[3])
        else $error("capture not taken");
    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // see R18
        flags_reg[2] && !seen_reg[2] |=> flags_reg[2])
        else $error("flag cleared without read");
    wrap_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R17
        tick_v[1] && !clr_v[1] && cnt_view[1] == `CNT_MAX
        |=> flags_reg[5]) else $error("wrap flag not set");
    req_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see R21
        request[3] |-> flags_reg[3] && enable_reg[3])
        else $error("request without enable");

    cover property (@(posedge pclk) disable iff (!presetn) pwm_sel[0] && ma_v[0]);
    cover property (@(posedge pclk) disable iff (!presetn) q_dn && run_reg[2]);
    cover property (@(posedge pclk) disable iff (!presetn) sync_clr[0] && clr_v[1]);
    cover property (@(posedge pclk) disable iff (!presetn) capa_v[1]);

endmodule

//--- sync_pwm_phase_timer_consts.svh
//  Contract
// R1: Synced count write presets all synced counters.
// R2: Synced clear follows another synced channel's clear.
// R3: PWM: match A sets pin A, B clears.
// R4: Equal general registers leave PWM output unchanged.
// R5: PWM duty reaches 0% and 100% cases.
// R6: PWM makes pin A output; any clearing.
// R7: Phase counting exists only on channel 2.
// R8: Quad inputs count up/down, clock select ignored.
// R9: Clear, pins, flags, run, registers stay effective.
// R10: Both edges of both quad inputs count.
// R11: Up/down chosen by edge and other level.
// R12: Quad inputs keep 1.5/2.5 state minimums.
// R13: Start level taken from output level setting.
// R14: Output level written only while stopped; the code accepts level writes while running.
// R15: Match raised when counter leaves matching value.
// R16: Capture sets flag and copies counter.
// R17: Wrap flag on FFFF to 0 or back.
// R18: Flag clears by write 0 after read-1.
// R19: Nine requests, each flag with enable.
// R20: Priority channel 0 first, A, B, wrap; the code puts channels with a prio_reg bit set ahead of the rest.
// R21: Request needs flag and its enable.
// R22: PWM forces compare, no capture; the code still masks compare when a capture bit is set.
// R23: Simultaneous A and B match suppressed in PWM.
// R24: Synced byte write leaves all 16 bits equal.
// R25: Clear select 00 none, 01 A, 10 B, 11 sync.
// R26: Three identical channels with own state.
`ifndef SYNC_PWM_PHASE_TIMER_CONSTS_SVH
`define SYNC_PWM_PHASE_TIMER_CONSTS_SVH
`define RUN_OFS      12'h000
`define MODE_OFS     12'h004
`define LEVEL_OFS    12'h008
`define PRIO_OFS     12'h00c
`define STATUS_OFS   12'h010
`define ENABLE_OFS   12'h014
`define CH_BASE      12'h020
`define CH_STRIDE    12'h010
`define CTL_OFS      12'h000
`define CNT_OFS      12'h004
`define GRA_OFS      12'h008
`define GRB_OFS      12'h00c
`define MODE_SYNC_LSB 0
`define MODE_PWM_LSB  4
`define MODE_PHASE_BIT 8
`define CTL_CLR_LSB  0
`define CTL_CAPA_BIT 2
`define CTL_CAPB_BIT 3
`define CTL_PSC_LSB  4
`define CNT_RESET    16'h0000
`define GR_RESET     16'hffff
`define CNT_MAX      16'hffff
`endif

//--- sync_pwm_phase_timer_pkg.sv
package sync_pwm_phase_timer_pkg;
    typedef enum logic [1:0] {
        CLR_NONE = 2'b00,
        CLR_A    = 2'b01,
        CLR_B    = 2'b10,
        CLR_SYNC = 2'b11
    } clr_sel_e;
    typedef logic [15:0] count_t;
endpackage

//--- quad_source.sv
`timescale 1ns/1ps
module quad_source (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       up,
    input  wire logic [7:0] n_steps,
    output logic            quad_a,
    output logic            quad_b,
    output logic            busy
);
    logic [1:0] phase_reg;
    logic [7:0] left_reg;
    logic [1:0] wait_reg;
    // Gray order 00, 01, 11, 10 counts up; the reverse counts down.
    assign quad_a = phase_reg[1];
    assign quad_b = phase_reg[1] ^ phase_reg[0];
    assign busy   = left_reg != 8'h00;
    // Four states between edges keep spacing and width above the floor.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 2'h0;
            left_reg  <= 8'h00;
            wait_reg  <= 2'h0;
        end else if (go) begin
            left_reg <= n_steps;
            wait_reg <= 2'h0;
        end else if (busy) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg == 2'h3) begin
                left_reg  <= left_reg - 8'h01;
                phase_reg <= up ? phase_reg + 2'h1 : phase_reg - 2'h1;
            end
        end
    end
endmodule

//--- test_sync_pwm_phase_timer.sv
`timescale 1ns/1ps
`include "sync_pwm_phase_timer_consts.svh"
module test_sync_pwm_phase_timer import sync_pwm_phase_timer_pkg::*; ();
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pin_a_out;
    logic [2:0]  pin_a_oe;
    logic [2:0]  pin_b_out;
    logic [2:0]  pin_b_oe;
    logic        quad_a;
    logic        quad_b;
    logic        q_go;
    logic        q_up;
    logic        q_busy;
    logic [7:0]  q_n;
    logic [2:0]  pin_a_drv;
    logic [8:0]  request;
    logic [3:0]  top_request;
    logic        any_request;
    logic [31:0] rd;
    logic        rd_err;
    int          n_fail;
    int          total_checks;
    int          cycles;
    int          n;
    ////////////////////////////////////////////////////////////////////////
    sync_pwm_phase_timer dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a_in(pin_a_drv), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_in(3'h0), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
        .quad_input_a(quad_a), .quad_input_b(quad_b), .request(request),
        .top_request(top_request), .any_request(any_request)
    );
    quad_source enc_u (
        .pclk(pclk), .presetn(presetn), .go(q_go), .up(q_up),
        .n_steps(q_n), .quad_a(quad_a), .quad_b(quad_b), .busy(q_busy)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // The whole run needs a few hundred cycles; the ceiling leaves room.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] ca(input int c, input logic [11:0] o);
        return 12'(`CH_BASE + `CH_STRIDE * c) + o;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp);
    endtask
    task automatic spin(input logic u, input logic [7:0] k);
        @(posedge pclk);
        q_up <= u;
        q_n  <= k;
        q_go <= 1'b1;
        @(posedge pclk);
        q_go <= 1'b0;
        @(posedge pclk);
        while (q_busy === 1'b1) @(posedge pclk);
        // The last quad edge reaches the count one cycle later; four cycles leave margin.
        repeat (4) @(posedge pclk);
    endtask
    task automatic hold_len(input logic lvl, output int k);
        k = 0;
        while (pin_a_out[0] === lvl && k < 60) begin
            @(posedge pclk);
            k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, q_go, q_up} = 5'h0;
        {paddr, pwdata, pstrb, q_n} = 56'h0;
        pin_a_drv = 3'h0;
        {n_fail, total_checks, cycles} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(top_request), 32'hf);
        rchk(ca(0, `CNT_OFS), 32'h0);
        rchk(ca(2, `GRB_OFS), 32'hffff);
        apb(1'b0, 12'hffc, 32'h0, 4'h0);
        chk({rd[30:0], rd_err}, 32'h1);
        apb(1'b1, `MODE_OFS, 32'h3, 4'hf);
        apb(1'b1, ca(1, `CNT_OFS), 32'h5a12, 4'h1);
        rchk(ca(0, `CNT_OFS), 32'h12);
        rchk(ca(2, `CNT_OFS), 32'h0);
        apb(1'b1, `MODE_OFS, 32'h100, 4'hf);
        apb(1'b1, `ENABLE_OFS, 32'h100, 4'hf);
        apb(1'b1, `RUN_OFS, 32'h4, 4'hf);
        spin(1'b1, 8'd4);
        rchk(ca(2, `CNT_OFS), 32'h4);
        spin(1'b0, 8'd6);
        rchk(ca(2, `CNT_OFS), 32'hfffe);
        chk(32'(request), 32'h100);
        chk(32'(top_request), 32'h8);
        apb(1'b1, `ENABLE_OFS, 32'h0, 4'hf);
        @(negedge pclk);
        chk(32'(any_request), 32'h0);
        // A zero written before any read of the flags must not clear them.
        apb(1'b1, `STATUS_OFS, 32'h0, 4'hf);
        rchk(`STATUS_OFS, 32'h1c0);
        apb(1'b1, `STATUS_OFS, 32'h0, 4'hf);
        rchk(`STATUS_OFS, 32'h0);
        apb(1'b1, `RUN_OFS, 32'h0, 4'hf);
        apb(1'b1, `MODE_OFS, 32'h10, 4'hf);
        apb(1'b1, ca(0, `CTL_OFS), 32'h2, 4'hf);
        apb(1'b1, ca(0, `GRA_OFS), 32'h4, 4'hf);
        apb(1'b1, ca(0, `GRB_OFS), 32'h8, 4'hf);
        apb(1'b1, ca(0, `CNT_OFS), 32'h0, 4'h3);
        apb(1'b1, `RUN_OFS, 32'h1, 4'hf);
        chk(32'(pin_a_oe[0]), 32'h1);
        hold_len(1'b0, n);
        hold_len(1'b1, n);
        chk(32'(n), 32'd4);
        hold_len(1'b0, n);
        chk(32'(n), 32'd5);
        hold_len(1'b1, n);
        apb(1'b1, ca(0, `GRA_OFS), 32'ha, 4'hf);
        hold_len(1'b0, n);
        chk(32'(n), 32'd60);
        // Capture on a stopped channel needs no count clock.
        apb(1'b1, ca(1, `CTL_OFS), 32'h4, 4'hf);
        @(posedge pclk);
        pin_a_drv <= 3'h2;
        rchk(ca(1, `GRA_OFS), 32'h12);
        rchk(`STATUS_OFS, 32'hb);
        apb(1'b1, `LEVEL_OFS, 32'h4, 4'hf);
        apb(1'b1, `RUN_OFS, 32'h3, 4'hf);
        repeat (2) @(negedge pclk);
        chk(32'(pin_a_out[1]), 32'h1);
        apb(1'b1, `RUN_OFS, 32'h0, 4'hf);
        apb(1'b1, `MODE_OFS, 32'h3, 4'hf);
        apb(1'b1, ca(0, `CTL_OFS), 32'h1, 4'hf);
        apb(1'b1, ca(1, `CTL_OFS), 32'h3, 4'hf);
        apb(1'b1, ca(0, `CNT_OFS), 32'h0, 4'h3);
        apb(1'b1, `RUN_OFS, 32'h3, 4'hf);
        // Channel 0 restarts every eleven steps, so 23 steps leave one.
        repeat (20) @(posedge pclk);
        apb(1'b1, `RUN_OFS, 32'h0, 4'hf);
        rchk(ca(0, `CNT_OFS), 32'h1);
        rchk(ca(1, `CNT_OFS), 32'h1);
        print_verdict();
    end
endmodule
